// file: verilog/wssd_top.v
// Waveform scale set decoder: gathers scale bits, decodes sets, scales points
`timescale 1ns/1ps
`default_nettype none
`include "wssd_regs.vh"
// Functional notes
// - Only bit zero of each fetched memory word is used as scale bit.
// - Two groups, four parameter types, eight sets each are stored.
// - Each parameter gathers sixteen bits, MSB first, from addresses eight apart.
// - Address order: set innermost, then bit, then type, group outermost.
// - Zero parameters keep low twelve bits as two's complement.
// - Binary power is field N9,N8 minus field N7,N6.
// - Decade exponent is -3*N5N4 plus N3N2 minus N1N0.
// - Negative scale word means not normalized, scale value reported zero.
// - Memory fraction is two to the power N11,N10 of horizontal word.
// - Set for a point is its address modulo eight, plus one.
// - Time is horizontal scale times address integer-divided by memory fraction.
// - Voltage is vertical scale times data word halved.
// - Point addresses span 0 to 4095, stepping 1, 2 or 4.
// - Two-channel full memory uses sets one and two; single channel eight equal.
// - Fetched words hold sign-extended sample above, scale bit at bit zero.
module wssd_top #(
  parameter AW = 12
) (
  input wire i_clk,                      // 25 MHz clock
  input wire i_rst_n,                    // Async reset, active low
  input wire i_start,                    // Start scale gathering, pulse
  input wire [AW-1:0] i_scale_base,      // Scale information start address
  output wire o_mem_rd,                  // Memory read request, level
  output reg [AW-1:0] o_mem_addr_r,      // Memory load address
  input wire i_mem_ack,                  // Memory word valid, pulse
  input wire [15:0] i_mem_data,          // Fetched memory word
  output reg o_done_r,                   // Scale sets decoded
  output wire o_busy,                    // Gathering in progress
  input wire i_pt_valid,                 // Point request valid
  output wire o_pt_ready,                // Point request ready
  input wire [AW-1:0] i_pt_addr,         // Point memory address
  input wire [15:0] i_pt_data,           // Point memory word
  input wire i_pt_group,                 // 0 original, 1 reset numbers
  output wire o_res_valid,               // Result valid
  input wire i_res_ready,                // Result ready
  output wire [2:0] o_res_set,           // Set index used, zero based
  output wire o_res_horizontal_scale,               // Horizontal scale normalized
  output wire [AW-1:0] o_res_time_mant,  // Time mantissa
  output wire [3:0] o_res_time_pow2,     // Time binary exponent, signed
  output wire [4:0] o_res_time_dec,      // Time decade exponent, signed
  output wire o_res_vertical_scale,               // Vertical scale normalized
  output wire [14:0] o_res_volt_mant,    // Voltage mantissa, signed
  output wire [3:0] o_res_volt_pow2,     // Voltage binary exponent, signed
  output wire [4:0] o_res_volt_dec,      // Voltage decade exponent, signed
  output wire [15:0] o_res_horizontal_zero,        // Horizontal zero, signed
  output wire [15:0] o_res_vertical_zero         // Vertical zero, signed
);
  // ==========================================
  // States
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FETCH = 4'h2;
  localparam [3:0] ST_WRITE = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  localparam RW = 3 + 1 + AW + 4 + 5 + 1 + 15 + 4 + 5 + 32;

  // ==========================================
  // Functions
  // Binary power and decade exponent of a scale word
  function [8:0] scale_exp;
    input [15:0] w;
    reg [3:0] p;
    reg [4:0] d;
    begin
      p = {2'h0, w[9:8]} - {2'h0, w[7:6]};
      d = {3'h0, w[3:2]} - {3'h0, w[1:0]} - 5'h03 * {3'h0, w[5:4]};
      scale_exp = {p, d};
    end
  endfunction

  // Sign extend a zero parameter from twelve bits
  function [15:0] zero_fix;
    input [15:0] w;
    begin
      zero_fix = {{4{w[`WSSD_ZERO_SIGN]}}, w[`WSSD_ZERO_HI:0]};
    end
  endfunction

  // ==========================================
  // Gathering control
  reg [3:0] state_r;
  reg [9:0] cnt_r;
  reg [2:0] widx_r;
  reg [15:0] acc_r [0:7];
  wire [2:0] c_set = cnt_r[2:0];
  wire [3:0] c_bit = cnt_r[6:3];
  wire [1:0] c_type = cnt_r[8:7];
  wire c_group = cnt_r[9];
  wire scale_bit = i_mem_data[0];
  wire take = (state_r == ST_FETCH) && i_mem_ack;
  wire last_word = (widx_r == 3'h7) && (cnt_r == `WSSD_LAST_COUNT);

  assign o_mem_rd = (state_r == ST_FETCH);
  assign o_busy = (state_r == ST_FETCH) || (state_r == ST_WRITE);

  // Shift registers, one per set
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_acc
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          acc_r[g] <= `WSSD_WORD_RST;
        end else if (take && (c_set == g)) begin
          acc_r[g] <= {acc_r[g][14:0], scale_bit};
        end
      end
    end
  endgenerate

  // Sequencer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= `WSSD_CNT_RST;
      widx_r <= 3'h0;
      o_mem_addr_r <= {AW{1'b0}};
      o_done_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (i_start) begin
            state_r <= ST_FETCH;
            cnt_r <= `WSSD_CNT_RST;
            o_mem_addr_r <= i_scale_base;
            o_done_r <= 1'b0;
          end
        end
        ST_FETCH: begin
          if (i_mem_ack) begin
            o_mem_addr_r <= o_mem_addr_r + {{(AW-1){1'b0}}, 1'b1};
            if (c_set == 3'h7 && c_bit == 4'hF) begin
              state_r <= ST_WRITE;
              widx_r <= 3'h0;
            end else begin
              cnt_r <= cnt_r + 10'h001;
            end
          end
        end
        ST_WRITE: begin
          widx_r <= widx_r + 3'h1;
          if (last_word) begin
            state_r <= ST_DONE;
            o_done_r <= 1'b1;
          end else if (widx_r == 3'h7) begin
            state_r <= ST_FETCH;
            cnt_r <= cnt_r + 10'h001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Set store
  wire is_zero_type = (c_type == `WSSD_TYPE_HORIZONTAL_ZERO) || (c_type == `WSSD_TYPE_VERTICAL_ZERO);
  wire [15:0] wr_word = is_zero_type ? zero_fix(acc_r[widx_r]) : acc_r[widx_r];
  reg [3:0] wlane;
  wire [63:0] rd_word;
  wire acc_pt;
  wire [3:0] rd_addr = {i_pt_group, i_pt_addr[2:0]};

  // Lane for the type being written, scale lanes high
  always @* begin
    wlane = 4'h0;
    case (c_type)
      `WSSD_TYPE_HSCALE: wlane = 4'h8;
      `WSSD_TYPE_VSCALE: wlane = 4'h4;
      `WSSD_TYPE_HORIZONTAL_ZERO: wlane = 4'h2;
      default: wlane = 4'h1;
    endcase
  end

  wssd_mem #(
    .AW(4),
    .LW(16),
    .LANES(4)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(state_r == ST_WRITE),
    .i_waddr({c_group, widx_r}),
    .i_wlane(wlane),
    .i_wdata(wr_word),
    .i_raddr(rd_addr),
    .o_rdata(rd_word)
  );

  // ==========================================
  // Point pipeline
  reg s1_v_r;
  reg [AW-1:0] s1_addr_r;
  reg [14:0] s1_data_r;
  reg [1:0] bcnt_r;
  reg [RW-1:0] ent0_r;
  reg [RW-1:0] ent1_r;
  wire [1:0] pend = bcnt_r + {1'b0, s1_v_r};

  assign o_pt_ready = o_done_r && (pend < 2'h2);
  assign acc_pt = i_pt_valid && o_pt_ready;

  // Stage one holds address and halved data during read
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_v_r <= 1'b0;
      s1_addr_r <= {AW{1'b0}};
      s1_data_r <= 15'h0000;
    end else begin
      s1_v_r <= acc_pt;
      if (acc_pt) begin
        s1_addr_r <= i_pt_addr;
        s1_data_r <= i_pt_data[15:1];
      end
    end
  end

  // Result compute from the selected set
  wire [15:0] hs = rd_word[63:48];
  wire [15:0] vs = rd_word[47:32];
  wire [15:0] hz = rd_word[31:16];
  wire [15:0] vz = rd_word[15:0];
  wire [8:0] he = scale_exp(hs);
  wire [8:0] ve = scale_exp(vs);
  wire horizontal_scale = !hs[`WSSD_SIGN_BIT];
  wire vertical_scale = !vs[`WSSD_SIGN_BIT];
  wire [1:0] frac_pow = hs[`WSSD_FRAC_HI:`WSSD_FRAC_LO];
  wire [AW-1:0] tcount = s1_addr_r >> frac_pow;
  wire [AW-1:0] tmant = horizontal_scale ? tcount : {AW{1'b0}};
  wire [14:0] vmant = vertical_scale ? s1_data_r : 15'h0000;
  wire [RW-1:0] res = {s1_addr_r[2:0], horizontal_scale, tmant, he, vertical_scale, vmant, ve, hz, vz};

  // Two-entry buffer, head in ent0
  wire pop = (bcnt_r != 2'h0) && i_res_ready;
  wire push = s1_v_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_r <= 2'h0;
      ent0_r <= {RW{1'b0}};
      ent1_r <= {RW{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (bcnt_r == 2'h0) begin
            ent0_r <= res;
          end else begin
            ent1_r <= res;
          end
          bcnt_r <= bcnt_r + 2'h1;
        end
        2'b01: begin
          ent0_r <= ent1_r;
          bcnt_r <= bcnt_r - 2'h1;
        end
        2'b11: begin
          if (bcnt_r == 2'h1) begin
            ent0_r <= res;
          end else begin
            ent0_r <= ent1_r;
            ent1_r <= res;
          end
        end
        default: begin
          bcnt_r <= bcnt_r;
        end
      endcase
    end
  end

  // Result outputs from the head entry
  assign o_res_valid = (bcnt_r != 2'h0);
  assign {o_res_set, o_res_horizontal_scale, o_res_time_mant, o_res_time_pow2, o_res_time_dec,
          o_res_vertical_scale, o_res_volt_mant, o_res_volt_pow2, o_res_volt_dec,
          o_res_horizontal_zero, o_res_vertical_zero} = ent0_r;
endmodule
`default_nettype wire

// file: verilog/wssd_regs.vh
// Constants for the waveform scale set decoder
`ifndef WSSD_REGS_VH
`define WSSD_REGS_VH
// ==========================================
// Scale information layout
`define WSSD_BITS_PER_PARAM 16
`define WSSD_NUM_SETS 8
`define WSSD_NUM_TYPES 4
`define WSSD_NUM_GROUPS 2
`define WSSD_TOTAL_WORDS 1024
`define WSSD_LAST_COUNT 10'h3FF
// ==========================================
// Parameter type codes
`define WSSD_TYPE_HSCALE 2'h0
`define WSSD_TYPE_VSCALE 2'h1
`define WSSD_TYPE_HORIZONTAL_ZERO 2'h2
`define WSSD_TYPE_VERTICAL_ZERO 2'h3
// ==========================================
// Field positions inside a scale word
`define WSSD_SIGN_BIT 15
`define WSSD_FRAC_HI 11
`define WSSD_FRAC_LO 10
`define WSSD_ZERO_HI 11
`define WSSD_ZERO_SIGN 11
// ==========================================
// Reset values
`define WSSD_WORD_RST 16'h0000
`define WSSD_CNT_RST 10'h000
`endif

// file: verilog/wssd_mem.v
// Scale set store with lane writes and registered read
`timescale 1ns/1ps
`default_nettype none
module wssd_mem #(
  parameter AW = 4,
  parameter LW = 16,
  parameter LANES = 4
) (
  input wire i_clk,                      // System clock
  input wire i_we,                       // Write strobe
  input wire [AW-1:0] i_waddr,           // Write index
  input wire [LANES-1:0] i_wlane,        // Lane select, one hot
  input wire [LW-1:0] i_wdata,           // Lane data
  input wire [AW-1:0] i_raddr,           // Read index
  output reg [LW*LANES-1:0] o_rdata      // Registered read word
);
  reg [LW*LANES-1:0] mem_r [0:(1<<AW)-1];
  integer lane_i;
  // Lane writes, one process so the store has a single driver
  always @(posedge i_clk) begin
    for (lane_i = 0; lane_i < LANES; lane_i = lane_i + 1) begin
      if (i_we && i_wlane[lane_i]) begin
        mem_r[i_waddr][lane_i*LW +: LW] <= i_wdata;
      end
    end
  end
  // Registered read
  always @(posedge i_clk) begin
    o_rdata <= mem_r[i_raddr];
  end
endmodule
`default_nettype wire

// file: sim/wssd_top_monitor.sv
// Port checker for the waveform scale set decoder
`timescale 1ns/1ps
`default_nettype none
module wssd_top_monitor #(
  parameter AW = 12
) (
  input wire i_clk,                  // Clock
  input wire i_rst_n,                // Reset, active low
  input wire i_start,                // Start pulse
  input wire [AW-1:0] i_scale_base,  // Scale start address
  input wire o_mem_rd,               // Read request
  input wire [AW-1:0] o_mem_addr_r,  // Load address
  input wire i_mem_ack,              // Word valid
  input wire o_done_r,               // Decode done
  input wire o_busy,                 // Gathering
  input wire i_pt_valid,             // Point valid
  input wire o_pt_ready,             // Point ready
  input wire [AW-1:0] i_pt_addr,     // Point address
  input wire o_res_valid,            // Result valid
  input wire i_res_ready,            // Result ready
  input wire [2:0] o_res_set,        // Set used
  input wire o_res_horizontal_scale,            // Horizontal normalized
  input wire [AW-1:0] o_res_time_mant, // Time mantissa
  input wire o_res_vertical_scale,            // Vertical normalized
  input wire [14:0] o_res_volt_mant, // Voltage mantissa
  input wire [15:0] o_res_horizontal_zero,     // Horizontal zero
  input wire [15:0] o_res_vertical_zero      // Vertical zero
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // Sequences
  sequence wait_s; o_mem_rd && !i_mem_ack; endsequence
  sequence fetch_s; o_mem_rd && i_mem_ack; endsequence
  sequence take_s; i_pt_valid && o_pt_ready && !o_res_valid; endsequence
  // ==========================================
  // Assertions
  rd_hold_a: assert property (wait_s |=> o_mem_rd && $stable(o_mem_addr_r))
    else $error("fetch request dropped");
  start_addr_a: assert property (i_start && !o_busy |=> o_mem_rd && o_mem_addr_r == $past(i_scale_base))
    else $error("fetch did not begin at base");
  addr_step_a: assert property (fetch_s |=> o_mem_addr_r == $past(o_mem_addr_r) + 1'b1)
    else $error("fetch address did not step");
  ready_done_a: assert property (o_pt_ready |-> o_done_r && !o_busy)
    else $error("point ready before done");
  done_hold_a: assert property (o_done_r && !i_start |=> o_done_r)
    else $error("done dropped");
  res_hold_a: assert property (o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_volt_mant))
    else $error("result changed while stalled");
  norm_zero_a: assert property (o_res_valid |-> (o_res_horizontal_scale || o_res_time_mant == 0) && (o_res_vertical_scale || o_res_volt_mant == 0))
    else $error("unnormalized scale not zero");
  zero_ext_a: assert property (o_res_valid |-> o_res_horizontal_zero[15:12] == {4{o_res_horizontal_zero[11]}} && o_res_vertical_zero[15:12] == {4{o_res_vertical_zero[11]}})
    else $error("zero not sign extended");
  set_pick_a: assert property (take_s ##1 !o_res_valid |=> o_res_valid && o_res_set == 3'($past(i_pt_addr, 2) % 8))
    else $error("wrong set or latency");
endmodule
`default_nettype wire

// file: sim/wssd_mem_model.sv
// Waveform memory read port model holding scale words
`timescale 1ns/1ps
`default_nettype none
module wssd_mem_model (
  input wire logic i_clk,          // Clock
  input wire logic i_rst_n,        // Reset, active low
  input wire logic i_rd,           // Read request
  input wire logic [11:0] i_addr,  // Load address
  input wire logic [11:0] i_base,  // Scale start address
  input wire logic [1:0] i_slow,   // Extra wait cycles
  output logic o_ack,              // Word valid pulse
  output logic [15:0] o_data       // Fetched word
);
  logic [15:0] words [0:63];
  logic [1:0] wait_r;
  logic [11:0] k;
  assign k = i_addr - i_base;
  // ==========================================
  // Answer after the chosen wait, churn data otherwise
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      wait_r <= 2'h0;
      o_data <= 16'h0000;
    end else if (i_rd && !o_ack && wait_r == i_slow) begin
      o_ack <= 1'b1;
      wait_r <= 2'h0;
      o_data <= {i_addr, 3'h5, words[{k[9:7], k[2:0]}][4'hf - k[6:3]]};
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      if (i_rd && !o_ack) wait_r <= wait_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: sim/wssd_top_tb.sv
// Self-checking bench for the waveform scale set decoder
`timescale 1ns/1ps
`default_nettype none
module wssd_top_tb;
  localparam int AW = 12;
  logic i_clk, i_rst_n, i_start, o_mem_rd, i_mem_ack, o_done_r, o_busy, i_pt_valid, o_pt_ready;
  logic i_pt_group, o_res_valid, i_res_ready, o_res_horizontal_scale, o_res_vertical_scale;
  logic [AW-1:0] i_scale_base, o_mem_addr_r, i_pt_addr, o_res_time_mant;
  logic [15:0] i_mem_data, i_pt_data, o_res_horizontal_zero, o_res_vertical_zero;
  logic [14:0] o_res_volt_mant;
  logic [4:0] o_res_time_dec, o_res_volt_dec;
  logic [3:0] o_res_time_pow2, o_res_volt_pow2;
  logic [2:0] o_res_set;
  logic [1:0] slow;
  int mismatches, comparisons, cyc;
  wssd_top #(.AW(AW)) i_wssd_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_scale_base(i_scale_base), .o_mem_rd(o_mem_rd), .o_mem_addr_r(o_mem_addr_r), .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data), .o_done_r(o_done_r), .o_busy(o_busy), .i_pt_valid(i_pt_valid),
    .o_pt_ready(o_pt_ready), .i_pt_addr(i_pt_addr), .i_pt_data(i_pt_data), .i_pt_group(i_pt_group),
    .o_res_valid(o_res_valid), .i_res_ready(i_res_ready), .o_res_set(o_res_set), .o_res_horizontal_scale(o_res_horizontal_scale),
    .o_res_time_mant(o_res_time_mant), .o_res_time_pow2(o_res_time_pow2), .o_res_time_dec(o_res_time_dec),
    .o_res_vertical_scale(o_res_vertical_scale), .o_res_volt_mant(o_res_volt_mant), .o_res_volt_pow2(o_res_volt_pow2),
    .o_res_volt_dec(o_res_volt_dec), .o_res_horizontal_zero(o_res_horizontal_zero), .o_res_vertical_zero(o_res_vertical_zero));
  wssd_mem_model i_wssd_mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(o_mem_rd), .i_addr(o_mem_addr_r),
    .i_base(i_scale_base), .i_slow(slow), .o_ack(i_mem_ack), .o_data(i_mem_data));
  // ==========================================
  // Helpers
  function automatic logic [15:0] sw(input int i);
    if (i[4]) return {4'ha, i[0], 5'h00, i[5:0]};
    return {i[2:0] == 3'h3, 3'h0, i[1:0], i[3:0] ^ 4'h5, i[5:0] ^ 6'h2a};
  endfunction
  function automatic logic [8:0] pd(input logic [15:0] w);
    logic [3:0] p;
    logic [4:0] e;
    p = w[9:8] - w[7:6];
    e = w[3:2] - 3 * w[5:4] - w[1:0];
    return {p, e};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_gather(input logic [1:0] s, input logic [11:0] b);
    int n;
    @(negedge i_clk);
    slow = s;
    i_scale_base = b;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    chk("done_clear", 16'h0, o_done_r);
    chk("busy", 16'h1, o_busy);
    n = 0;
    while (o_done_r !== 1'b1 && n < 6000) begin @(negedge i_clk); n++; end
    chk("done", 16'h1, o_done_r);
  endtask
  task automatic send(input logic [11:0] a, input logic g);
    int n;
    @(negedge i_clk);
    i_pt_valid = 1'b1;
    i_pt_addr = a;
    i_pt_data = {a[3:0], a};
    i_pt_group = g;
    n = 0;
    while (o_pt_ready !== 1'b1 && n < 50) begin @(negedge i_clk); n++; end
    @(negedge i_clk);
    i_pt_valid = 1'b0;
  endtask
  task automatic recv(input logic [11:0] a, input logic g);
    int n;
    logic [15:0] hs, vs, hz, vz, d;
    hs = sw({g, 2'h0, a[2:0]});
    vs = sw({g, 2'h1, a[2:0]});
    hz = sw({g, 2'h2, a[2:0]});
    vz = sw({g, 2'h3, a[2:0]});
    d = {a[3:0], a};
    @(negedge i_clk);
    i_res_ready = 1'b1;
    n = 0;
    while (o_res_valid !== 1'b1 && n < 50) begin @(negedge i_clk); n++; end
    chk("set", a[2:0], o_res_set);
    chk("norm", {!hs[15], !vs[15]}, {o_res_horizontal_scale, o_res_vertical_scale});
    chk("time", hs[15] ? 12'h000 : a >> hs[11:10], o_res_time_mant);
    chk("texp", pd(hs), {o_res_time_pow2, o_res_time_dec});
    chk("volt", vs[15] ? 15'h0000 : d[15:1], o_res_volt_mant);
    chk("vexp", pd(vs), {o_res_volt_pow2, o_res_volt_dec});
    chk("horizontal_zero", {{4{hz[11]}}, hz[11:0]}, o_res_horizontal_zero);
    chk("vertical_zero", {{4{vz[11]}}, vz[11:0]}, o_res_vertical_zero);
    @(negedge i_clk);
    i_res_ready = 1'b0;
  endtask
  task automatic t_points(input logic g, input int a0, input int st);
    for (int j = 0; j < 8; j += 2) begin
      send(12'(a0 + j * st), g);
      send(12'(a0 + (j + 1) * st), g);
      repeat (3) @(negedge i_clk);
      chk("full", 16'h0, o_pt_ready);
      recv(12'(a0 + j * st), g);
      recv(12'(a0 + (j + 1) * st), g);
    end
  endtask
  // ==========================================
  // Clock and cycle ceiling
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc >= 40000) begin mismatches++; results(); end
  end
  // Main sequence
  initial begin
    {i_rst_n, i_start, i_pt_valid, i_pt_group, i_res_ready, slow} = 7'h00;
    {i_scale_base, i_pt_addr, i_pt_data} = 40'h0;
    for (int i = 0; i < 64; i++) i_wssd_mem_model.words[i] = sw(i);
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk("ready_early", 16'h0, o_pt_ready);
    t_gather(2'h0, 12'h100);
    t_points(1'b0, 0, 1);
    t_points(1'b1, 1, 2);
    t_gather(2'h2, 12'hf80);
    t_points(1'b0, 4066, 4);
    t_points(1'b1, 4064, 4);
    results();
  end
endmodule
bind wssd_top wssd_top_monitor #(.AW(AW)) i_wssd_top_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_start(i_start), .i_scale_base(i_scale_base), .o_mem_rd(o_mem_rd), .o_mem_addr_r(o_mem_addr_r),
  .i_mem_ack(i_mem_ack), .o_done_r(o_done_r), .o_busy(o_busy), .i_pt_valid(i_pt_valid),
  .o_pt_ready(o_pt_ready), .i_pt_addr(i_pt_addr), .o_res_valid(o_res_valid), .i_res_ready(i_res_ready),
  .o_res_set(o_res_set), .o_res_horizontal_scale(o_res_horizontal_scale), .o_res_time_mant(o_res_time_mant),
  .o_res_vertical_scale(o_res_vertical_scale), .o_res_volt_mant(o_res_volt_mant), .o_res_horizontal_zero(o_res_horizontal_zero),
  .o_res_vertical_zero(o_res_vertical_zero));
`default_nettype wire
